//--- bdrl_pkg.sv
// Purpose: constants for the background debug register set and lockout
// Assumes: one 25 MHz clock, byte-wide parallel register port
// Notes: bit positions, addresses and timing counts live here; command field slices and read offsets are literal in bdrl_regs
package bdrl_pkg;
  localparam logic [15:0] ADDR_CMD = 16'hFF00;
  localparam logic [15:0] ADDR_STATE = 16'hFF01;
  localparam logic [15:0] ADDR_SHIFT_HI = 16'hFF02;
  localparam logic [15:0] ADDR_SHIFT_LO = 16'hFF03;
  localparam logic [15:0] ADDR_TADDR_HI = 16'hFF04;
  localparam logic [15:0] ADDR_TADDR_LO = 16'hFF05;
  localparam logic [15:0] ADDR_CCR = 16'hFF06;
  localparam logic [7:0] MAP_PAGE = 8'hFF;
  // status bit positions
  localparam int ST_PERMIT = 7;
  localparam int ST_ACTIVE = 6;
  localparam int ST_TAG = 5;
  localparam int ST_SDV = 4;
  localparam int ST_TRACE = 3;
  localparam int ST_CLKSEL = 2;
  localparam logic [7:0] ST_ANY_MASK = 8'h38;
  localparam logic [7:0] ST_RESET = 8'h00;
  // instruction bit positions
  localparam int IN_HW = 7;
  localparam int IN_DATA = 6;
  localparam int IN_READ = 5;
  localparam int IN_BACKGROUND_REQUEST_BIT = 4;
  localparam int IN_WORD = 3;
  localparam int IN_MAP = 2;
  localparam logic [7:0] IN_BACKGROUND_REQUEST_BIT_CODE = 8'h90;
  localparam logic [7:0] IN_RESET = 8'h00;
  localparam logic [7:0] IN_HW_MASK = 8'hFC;
  // exit field codes
  localparam logic [1:0] EX_NONE = 2'h0;
  localparam logic [1:0] EX_GO = 2'h1;
  localparam logic [1:0] EX_TRACE = 2'h2;
  localparam logic [1:0] EX_TAG_AND_RESUME_COMMAND = 2'h3;
  // target register codes
  localparam logic [2:0] RG_NEXT = 3'h2;
  localparam logic [2:0] RG_PC = 3'h3;
  localparam logic [2:0] RG_D = 3'h4;
  localparam logic [2:0] RG_X = 3'h5;
  localparam logic [2:0] RG_Y = 3'h6;
  localparam logic [2:0] RG_SP = 3'h7;
  // lockout bit in the eeprom module control byte
  localparam int LOCK_BIT = 7;
  localparam logic [1:0] MODE_SPECIAL_SINGLE = 2'h0;
  localparam logic [1:0] MODE_SPECIAL_PERIPH = 2'h1;
  // timing, in clock cycles of the counting domain
  localparam int ACT_DELAY = 4;
  localparam int TAG_DELAY = 16;
  localparam int IDLE_LIMIT = 512;
  localparam int DEBUG_CLOCK_SELECT_HOLD = 150;
endpackage

//--- bdrl_delay.sv
// Purpose: counts a fixed number of enabled ticks after a start pulse
// Assumes: start restarts the count; done is a one-cycle pulse
// Notes: used for the active-flag and tagging write delays
`timescale 1ns/1ps
`default_nettype none
module bdrl_delay #(
  parameter int COUNT = 4
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic start,
  input wire logic tick,
  output logic done
);
  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] cnt_ff;
  logic busy_ff;
  // count down only on ticks; the last tick fires done
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_ff <= W'(COUNT);
        busy_ff <= 1'b1;
      end else if (busy_ff && tick) begin
        cnt_ff <= cnt_ff - 1'b1;
        if (cnt_ff == W'(1)) begin
          busy_ff <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- bdrl_idle.sv
// Purpose: watches host falling edges on the serial pin for idle time
// Assumes: pin level is synchronous; tick is one debug-clock cycle
// Notes: timeout is one pulse; counting restarts at each falling edge
`timescale 1ns/1ps
`default_nettype none
module bdrl_idle #(
  parameter int LIMIT = 512
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic pinIn,
  input wire logic tick,
  output logic timeout
);
  localparam int W = $clog2(LIMIT + 1);
  logic [W-1:0] cnt_ff;
  logic pinPrev_ff;
  logic armed_ff;
  wire logic fall = pinPrev_ff && !pinIn;
  // one timeout per gap; a new edge rearms the watcher
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
      pinPrev_ff <= 1'b1;
      armed_ff <= 1'b0;
      timeout <= 1'b0;
    end else begin
      pinPrev_ff <= pinIn;
      timeout <= 1'b0;
      if (fall) begin
        cnt_ff <= '0;
        armed_ff <= 1'b1;
      end else if (armed_ff && tick) begin
        cnt_ff <= cnt_ff + 1'b1;
        if (cnt_ff == W'(LIMIT - 1)) begin
          armed_ff <= 1'b0;
          timeout <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- bdrl_regs.sv
// Purpose: debug register bytes, lockout latch and command-field decode
// Assumes: parallel byte bus inputs synchronous to mclk; serial engine
//   outside delivers shifted command bytes and shift-done pulses
// Notes: serial bit protocol and firmware ROM contents are not here
`timescale 1ns/1ps
`default_nettype none
module bdrl_regs (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [1:0] modeSel,
  input wire logic [7:0] shadowByte,
  input wire logic eClkSlow,
  input wire logic debugClkTick,
  input wire logic eClkTick,
  input wire logic bgClkTick,
  input wire logic backgroundPinIn,
  input wire logic serCmdValid,
  input wire logic [7:0] serCmdByte,
  input wire logic shiftDone,
  input wire logic [15:0] shiftIn,
  input wire logic addrLoad,
  input wire logic [15:0] addrIn,
  input wire logic enterDebug,
  input wire logic [7:0] userCcr,
  input wire logic busSel,
  input wire logic busWr,
  input wire logic [15:0] busAddr,
  input wire logic [7:0] busWdata,
  output logic [7:0] busRdata,
  output logic busHit,
  output logic debugActive,
  output logic romMapped,
  output logic lockoutActive,
  output logic resetVectorBlock,
  output logic serialEnable,
  output logic useEClock,
  output logic backgroundRequest,
  output logic traceRequest,
  output logic goRequest,
  output logic tagRequest,
  output logic [2:0] targetReg,
  output logic targetValid
);
  logic [7:0] cmd_ff;
  logic [7:0] state_ff;
  logic [15:0] shift_ff;
  logic [15:0] taddr_ff;
  logic [7:0] ccr_ff;
  logic [7:0] ctrl_ff;
  logic capDone_ff;
  logic tagOn_ff;
  logic clkSelLive_ff;
  logic [7:0] nxt_busRdata;
  logic actDone;
  logic tagDone;
  logic idleTimeout;
  // eClkTick and bgClkTick belong to the serial engine, which owns bit
  // timing; only the selected debug tick is counted here

  // address decode of the seven debug bytes
  wire logic lockedOut = !ctrl_ff[bdrl_pkg::LOCK_BIT];
  wire logic special = (modeSel == bdrl_pkg::MODE_SPECIAL_SINGLE) ||
                       (modeSel == bdrl_pkg::MODE_SPECIAL_PERIPH);
  wire logic isHw = cmd_ff[bdrl_pkg::IN_HW];
  wire logic mapSel = isHw && cmd_ff[bdrl_pkg::IN_MAP];
  // registers answer only while the map is in: active, or a map-select access
  wire logic inMap = state_ff[bdrl_pkg::ST_ACTIVE] || mapSel;
  wire logic pageHit = busSel && (busAddr[15:8] == bdrl_pkg::MAP_PAGE) && inMap;
  wire logic regHit = pageHit && (busAddr[7:0] <= bdrl_pkg::ADDR_CCR[7:0]);
  wire logic wrEn = regHit && busWr;
  wire logic wrCmd = wrEn && (busAddr == bdrl_pkg::ADDR_CMD);
  wire logic wrState = wrEn && (busAddr == bdrl_pkg::ADDR_STATE);
  wire logic wrShHi = wrEn && (busAddr == bdrl_pkg::ADDR_SHIFT_HI);
  wire logic wrShLo = wrEn && (busAddr == bdrl_pkg::ADDR_SHIFT_LO);
  wire logic wrCcr = wrEn && (busAddr == bdrl_pkg::ADDR_CCR);

  // instruction is parallel-writable only in special peripheral mode
  wire logic cmdBusOk = (modeSel == bdrl_pkg::MODE_SPECIAL_PERIPH);

  // exit field and target field of a firmware command
  wire logic [1:0] exitAction = cmd_ff[4:3];
  wire logic [2:0] regField = cmd_ff[2:0];

  // a serial byte only counts while tagging is off; every serial side effect
  // goes through this one strobe so none of them leaks out during tagging
  wire logic serTake = serCmdValid && !tagOn_ff;

  // status write mask depends on command type
  // bit 6 bypasses the mask; only under a firmware command does it go through the delay unit
  wire logic [7:0] stWrMask = bdrl_pkg::ST_ANY_MASK |
    (8'h01 << bdrl_pkg::ST_PERMIT) |
    (isHw ? (8'h01 << bdrl_pkg::ST_CLKSEL) : 8'h00);
  // the lockout blocks entry even when firmware has set the permit bit
  wire logic permitEntry = state_ff[bdrl_pkg::ST_PERMIT] && !lockedOut;
  wire logic actWrite = wrState && !isHw;
  wire logic tagWrite = wrState && busWdata[bdrl_pkg::ST_TAG];

  // the delayed active-flag write lands after the counted cycles
  bdrl_delay #(.COUNT(bdrl_pkg::ACT_DELAY)) actDelay (
    .mclk(mclk),
    .nrst(nrst),
    .start(actWrite),
    .tick(1'b1),
    .done(actDone)
  );

  logic actVal_ff;
  logic tagSet;
  assign tagSet = (serTake && !serCmdByte[bdrl_pkg::IN_HW] &&
                   serCmdByte[4:3] == bdrl_pkg::EX_TAG_AND_RESUME_COMMAND) || tagWrite;

  // tagging takes over 16 cycles after the bit is written
  bdrl_delay #(.COUNT(bdrl_pkg::TAG_DELAY)) tagDelay (
    .mclk(mclk),
    .nrst(nrst),
    .start(tagSet),
    .tick(1'b1),
    .done(tagDone)
  );

  // idle watcher counts debug-clock ticks between host falling edges
  bdrl_idle #(.LIMIT(bdrl_pkg::IDLE_LIMIT)) idleWatch (
    .mclk(mclk),
    .nrst(nrst),
    .pinIn(backgroundPinIn),
    .tick(debugClkTick),
    .timeout(idleTimeout)
  );

  // lockout copy is caught after reset release, never inside reset
  // there is no bus path into this latch: the lockout only changes through
  // the shadow byte, and only at the next reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= 8'h00;
      capDone_ff <= 1'b0;
    end else if (!capDone_ff) begin
      ctrl_ff <= shadowByte;
      capDone_ff <= 1'b1;
    end
  end

  // instruction: serial load, bus write in peripheral mode, idle clear
  // an idle clear outranks a byte arriving in the same cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmd_ff <= bdrl_pkg::IN_RESET;
    end else if (idleTimeout) begin
      cmd_ff <= bdrl_pkg::IN_RESET;
    end else if (serTake) begin
      cmd_ff <= serCmdByte;
    end else if (wrCmd && cmdBusOk) begin
      cmd_ff <= busWdata;
    end
  end

  // status register: entry, delayed clear, firmware bits, hardware set
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= bdrl_pkg::ST_RESET;
      actVal_ff <= 1'b0;
    end else if (!capDone_ff) begin
      state_ff <= bdrl_pkg::ST_RESET;
      state_ff[bdrl_pkg::ST_ACTIVE] <= special && shadowByte[bdrl_pkg::LOCK_BIT];
    end else begin
      // firmware bits take the masked write; the active bit waits for the
      // delayed landing, so a stray store cannot drop the map at once
      if (wrState) begin
        state_ff <= (state_ff & ~stWrMask) | (busWdata & stWrMask);
        state_ff[bdrl_pkg::ST_ACTIVE] <= state_ff[bdrl_pkg::ST_ACTIVE];
      end
      if (actWrite) begin
        actVal_ff <= busWdata[bdrl_pkg::ST_ACTIVE];
      end
      // entry further down wins over a delayed clear landing in its cycle
      if (actDone) begin
        state_ff[bdrl_pkg::ST_ACTIVE] <= actVal_ff && !lockedOut;
      end
      // a shift finishing in the cycle of a clear leaves the flag set
      if (shiftDone) begin
        state_ff[bdrl_pkg::ST_SDV] <= 1'b1;
      end else if (wrShHi || wrShLo || serTake) begin
        state_ff[bdrl_pkg::ST_SDV] <= 1'b0;
      end
      if (serTake && !serCmdByte[bdrl_pkg::IN_HW]) begin
        if (serCmdByte[4:3] == bdrl_pkg::EX_TRACE) begin
          state_ff[bdrl_pkg::ST_TRACE] <= 1'b1;
        end
        if (serCmdByte[4:3] == bdrl_pkg::EX_TAG_AND_RESUME_COMMAND) begin
          state_ff[bdrl_pkg::ST_TAG] <= 1'b1;
        end
      end
      if (enterDebug && permitEntry) begin
        state_ff[bdrl_pkg::ST_ACTIVE] <= 1'b1;
        state_ff[bdrl_pkg::ST_TAG] <= 1'b0;
      end
    end
  end

  // tagging mode holds off serial until the next debug entry
  // a second tag request restarts the count instead of stacking; entry
  // clears tagging first, so a late count cannot arm it again
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tagOn_ff <= 1'b0;
    end else if (enterDebug && permitEntry) begin
      tagOn_ff <= 1'b0;
    end else if (tagDone && state_ff[bdrl_pkg::ST_TAG]) begin
      tagOn_ff <= 1'b1;
    end
  end

  // clock select: the new rate starts with the next serial command
  // a switch written mid-command keeps the old rate for that command
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clkSelLive_ff <= 1'b0;
    end else if (serTake) begin
      clkSelLive_ff <= state_ff[bdrl_pkg::ST_CLKSEL];
    end
  end

  // shift, temp address and saved condition codes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      shift_ff <= 16'h0000;
      taddr_ff <= 16'h0000;
      ccr_ff <= 8'h00;
    end else begin
      if (shiftDone) begin
        shift_ff <= shiftIn;
      end else if (wrShHi) begin
        shift_ff[15:8] <= busWdata;
      end else if (wrShLo) begin
        shift_ff[7:0] <= busWdata;
      end
      if (addrLoad) begin
        taddr_ff <= addrIn; // address is hardware-written only
      end
      // entry capture of the user flags outranks a host write in that cycle
      if (enterDebug && permitEntry) begin
        ccr_ff <= userCcr;
      end else if (wrCcr) begin
        ccr_ff <= busWdata;
      end
    end
  end

  // read mux; unmapped bytes of the page read as zero
  // status bits 1..0 have no storage and always read as zero
  always_comb begin
    nxt_busRdata = 8'h00;
    case (busAddr[2:0])
      3'h0: nxt_busRdata = cmd_ff;
      3'h1: nxt_busRdata = state_ff & 8'hFC;
      3'h2: nxt_busRdata = shift_ff[15:8];
      3'h3: nxt_busRdata = shift_ff[7:0];
      3'h4: nxt_busRdata = taddr_ff[15:8];
      3'h5: nxt_busRdata = taddr_ff[7:0];
      3'h6: nxt_busRdata = ccr_ff;
      default: nxt_busRdata = 8'h00;
    endcase
  end

  // registered outputs
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busRdata <= 8'h00;
      busHit <= 1'b0;
      debugActive <= 1'b0;
      romMapped <= 1'b0;
      lockoutActive <= 1'b0;
      resetVectorBlock <= 1'b0;
      serialEnable <= 1'b0;
      useEClock <= 1'b0;
      backgroundRequest <= 1'b0;
      traceRequest <= 1'b0;
      goRequest <= 1'b0;
      tagRequest <= 1'b0;
      targetReg <= 3'h0;
      targetValid <= 1'b0;
    end else begin
      busRdata <= regHit ? nxt_busRdata : 8'h00;
      busHit <= pageHit;
      // the lockout masks both output views of the active flag, but not the status byte readback
      debugActive <= state_ff[bdrl_pkg::ST_ACTIVE] && !lockedOut;
      romMapped <= inMap && !lockedOut;
      lockoutActive <= capDone_ff && lockedOut;
      // a locked part started in special single-chip must not fetch the vector
      resetVectorBlock <= capDone_ff && lockedOut &&
        (modeSel == bdrl_pkg::MODE_SPECIAL_SINGLE);
      serialEnable <= !tagOn_ff;
      // slow bus clock overrides the select bit
      useEClock <= eClkSlow || clkSelLive_ff;
      // a plain decode; entry itself is what the permit bit gates
      backgroundRequest <= (cmd_ff == bdrl_pkg::IN_BACKGROUND_REQUEST_BIT_CODE);
      traceRequest <= !isHw && exitAction == bdrl_pkg::EX_TRACE;
      goRequest <= !isHw && exitAction == bdrl_pkg::EX_GO;
      tagRequest <= !isHw && exitAction == bdrl_pkg::EX_TAG_AND_RESUME_COMMAND;
      targetReg <= regField;
      // codes below 010 are unused and never raise the valid flag
      targetValid <= !isHw && regField >= bdrl_pkg::RG_NEXT;
    end
  end
endmodule
`default_nettype wire

//--- bdrl_regs_sva.sv
// Purpose: port-level checks of the debug register block
// Assumes: mclk is the only clock; nrst low aborts every check
// Notes: decode checks look two edges past the command byte strobe
`timescale 1ns/1ps
`default_nettype none
module bdrl_regs_sva (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [1:0] modeSel,
  input wire logic eClkSlow,
  input wire logic serCmdValid,
  input wire logic [7:0] serCmdByte,
  input wire logic busSel,
  input wire logic busWr,
  input wire logic [15:0] busAddr,
  input wire logic [7:0] busRdata,
  input wire logic debugActive,
  input wire logic romMapped,
  input wire logic lockoutActive,
  input wire logic resetVectorBlock,
  input wire logic serialEnable,
  input wire logic useEClock,
  input wire logic backgroundRequest,
  input wire logic goRequest,
  input wire logic traceRequest,
  input wire logic [2:0] targetReg,
  input wire logic targetValid
);
  // one domain, so clock and reset are given once for all checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // a firmware byte the serial side is willing to take
  wire logic fwCmd = serCmdValid && serialEnable && !serCmdByte[7];
  lock_no_active_a: assert property (lockoutActive |-> !debugActive)
    else $error("debug active while locked out");
  locked_vector_a: assert property (lockoutActive && modeSel == 2'h0 |-> resetVectorBlock)
    else $error("reset vector not blocked under lockout");
  active_maps_rom_a: assert property (debugActive |-> romMapped)
    else $error("active without rom mapped");
  unmapped_read_a: assert property (busSel && !busWr && busAddr[15:8] != bdrl_pkg::MAP_PAGE
    |=> busRdata == 8'h00)
    else $error("read outside debug page not zero");
  background_request_bit_decode_a: assert property (serCmdValid && serialEnable
    && serCmdByte == bdrl_pkg::IN_BACKGROUND_REQUEST_BIT_CODE |-> ##2 backgroundRequest)
    else $error("background code not decoded");
  go_decode_a: assert property (fwCmd && serCmdByte[4:3] == bdrl_pkg::EX_GO
    |-> ##2 goRequest && !traceRequest)
    else $error("resume code not decoded");
  trace_decode_a: assert property (fwCmd && serCmdByte[4:3] == bdrl_pkg::EX_TRACE
    |-> ##2 traceRequest && !goRequest)
    else $error("single step code not decoded");
  target_decode_a: assert property (fwCmd && serCmdByte[2:1] != 2'h0
    |-> ##2 targetValid && targetReg == $past(serCmdByte[2:0], 2))
    else $error("target field not decoded");
  tag_delay_a: assert property (fwCmd && serCmdByte[4:3] == bdrl_pkg::EX_TAG_AND_RESUME_COMMAND
    |=> serialEnable [*8] ##[6:12] !serialEnable)
    else $error("serial side not shut after tag delay");
  slow_bus_e_clock_a: assert property (eClkSlow [*3] |-> useEClock)
    else $error("slow bus clock not forced");
endmodule
bind bdrl_regs bdrl_regs_sva chk (.mclk, .nrst, .modeSel, .eClkSlow, .serCmdValid, .serCmdByte,
  .busSel, .busWr, .busAddr, .busRdata, .debugActive, .romMapped, .lockoutActive,
  .resetVectorBlock, .serialEnable, .useEClock, .backgroundRequest, .goRequest,
  .traceRequest, .targetReg, .targetValid);
`default_nettype wire

//--- bdrl_host.sv
// Purpose: behavioural debug host on the serial pin side
// Assumes: the serial engine is abstracted to one byte strobe a command
// Notes: pin idles high through its pull-up between commands
`timescale 1ns/1ps
`default_nettype none
module bdrl_host (
  input wire logic mclk,
  output logic pinLevel,
  output logic cmdValid,
  output logic [7:0] cmdByte
);
  // released lines at time zero
  initial begin
    pinLevel = 1'b1;
    cmdValid = 1'b0;
    cmdByte = 8'h00;
  end
  // falling edge, bit time, byte strobe, then a quiet gap chosen by caller
  // only whole debug-map commands are sent, never word writes over the
  // instruction byte
  task automatic sendCmd(input logic [7:0] b, input int gap);
    @(negedge mclk);
    pinLevel = 1'b0;
    repeat (2) @(negedge mclk);
    pinLevel = 1'b1;
    cmdValid = 1'b1;
    cmdByte = b;
    @(negedge mclk);
    cmdValid = 1'b0;
    cmdByte = ~b; // stale byte never left standing
    repeat (gap) @(negedge mclk); // quiet gap of the length the caller chose
  endtask
endmodule
`default_nettype wire

//--- tb.sv
// Purpose: self-checking bench for the debug register block
// Assumes: inputs change on falling edges; reads land one cycle later
// Notes: unused clock enables are tied low, they feed no logic
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk, nrst, eClkSlow, debugClkTick, shiftDone, addrLoad, enterDebug, busSel, busWr;
  logic [1:0] modeSel;
  logic [7:0] shadowByte, userCcr, busWdata, rdv;
  logic [15:0] shiftIn, addrIn, busAddr, n;
  wire logic backgroundPinIn, serCmdValid, busHit, debugActive, romMapped, lockoutActive;
  wire logic resetVectorBlock, serialEnable, useEClock, backgroundRequest, traceRequest;
  wire logic goRequest, tagRequest, targetValid;
  wire logic [7:0] serCmdByte, busRdata;
  wire logic [2:0] targetReg;
  int mismatches, tests_run;
  bdrl_host host (.mclk, .pinLevel(backgroundPinIn), .cmdValid(serCmdValid),
    .cmdByte(serCmdByte));
  bdrl_regs DUT (.mclk, .nrst, .modeSel, .shadowByte, .eClkSlow, .debugClkTick,
    .eClkTick(1'b0), .bgClkTick(1'b0), .backgroundPinIn, .serCmdValid, .serCmdByte,
    .shiftDone, .shiftIn, .addrLoad, .addrIn, .enterDebug, .userCcr, .busSel, .busWr,
    .busAddr, .busWdata, .busRdata, .busHit, .debugActive, .romMapped, .lockoutActive,
    .resetVectorBlock, .serialEnable, .useEClock, .backgroundRequest, .traceRequest,
    .goRequest, .tagRequest, .targetReg, .targetValid);
  // 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one byte access, held across the taking edge
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    busSel = 1'b1;
    busWr = w;
    busAddr = a;
    busWdata = d;
    @(negedge mclk);
    rdv = busRdata;
    busSel = 1'b0;
    busWr = 1'b0;
    @(negedge mclk); // idle beat, so a next call never re-raises the strobe at once
  endtask
  task rdChk(input logic [15:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(rdv, e);
  endtask
  task doReset(input logic [1:0] m, input logic [7:0] s);
    nrst = 1'b0;
    modeSel = m;
    shadowByte = s;
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    repeat (3) @(negedge mclk);
  endtask
  task pulseEnter;
    enterDebug = 1'b1;
    @(negedge mclk);
    enterDebug = 1'b0;
  endtask
  task testResetRegs;
    doReset(2'h0, 8'hFF);
    chk(debugActive, 1'b1);
    rdChk(16'hFF01, 8'h40);
    rdChk(16'hFF00, 8'h00);
    rdChk(16'h0FC0, 8'h00);
    acc(1'b1, 16'hFF01, 8'hC0);
    shiftDone = 1'b1;
    shiftIn = 16'hA55A;
    addrLoad = 1'b1;
    addrIn = 16'h1234;
    userCcr = 8'h3C;
    pulseEnter();
    shiftDone = 1'b0;
    addrLoad = 1'b0;
    rdChk(16'hFF02, 8'hA5);
    rdChk(16'hFF03, 8'h5A);
    acc(1'b1, 16'hFF04, 8'hEE);
    rdChk(16'hFF04, 8'h12);
    rdChk(16'hFF05, 8'h34);
    rdChk(16'hFF01, 8'hD0);
    rdChk(16'hFF06, 8'h3C);
    acc(1'b1, 16'hFF06, 8'hC3);
    rdChk(16'hFF06, 8'hC3);
  endtask
  task testStatusWrite;
    acc(1'b1, 16'hFF01, 8'hC4);
    rdChk(16'hFF01, 8'hC0);
    acc(1'b1, 16'hFF01, 8'h80);
    n = 16'h0000;
    while (debugActive === 1'b1 && n < 16'h0014) begin
      @(negedge mclk);
      n++;
    end
    chk(n, 16'h0005);
    rdChk(16'hFF01, 8'h00);
  endtask
  task testHwCmd;
    doReset(2'h0, 8'hFF);
    eClkSlow = 1'b1;
    repeat (4) @(negedge mclk);
    chk(useEClock, 1'b1);
    eClkSlow = 1'b0;
    repeat (4) @(negedge mclk);
    chk(useEClock, 1'b0);
    host.sendCmd(8'hC4, 2);
    acc(1'b1, 16'hFF01, 8'h04);
    rdChk(16'hFF01, 8'h44);
    chk(useEClock, 1'b0);
    host.sendCmd(8'hE4, 150);
    chk(useEClock, 1'b1);
    doReset(2'h2, 8'hFF);
    chk(debugActive, 1'b0);
    host.sendCmd(8'hC4, 2);
    rdChk(16'hFF00, 8'hC4);
    host.sendCmd(8'hC0, 2);
    rdChk(16'hFF00, 8'h00);
    doReset(2'h1, 8'hFF);
    acc(1'b1, 16'hFF00, 8'h80);
    rdChk(16'hFF00, 8'h80);
  endtask
  task testFwDecode;
    doReset(2'h0, 8'hFF);
    for (int i = 2; i < 8; i++) begin
      host.sendCmd({5'b01100, i[2:0]}, 2);
      chk({targetValid, targetReg}, {1'b1, i[2:0]});
    end
    host.sendCmd(8'h00, 2);
    chk({goRequest, traceRequest, targetValid}, 3'b000);
    host.sendCmd(8'h08, 2);
    chk({goRequest, traceRequest, tagRequest}, 3'b100);
    host.sendCmd(8'h10, 2);
    chk({goRequest, traceRequest, tagRequest}, 3'b010);
    host.sendCmd(8'h90, 2);
    chk(backgroundRequest, 1'b1);
    host.sendCmd(8'h18, 0);
    n = 16'h0000;
    while (serialEnable === 1'b1 && n < 16'h0028) begin
      @(negedge mclk);
      n++;
    end
    chk(n >= 16'h000E && n <= 16'h0012, 1'b1);
    host.sendCmd(8'h90, 2);
    chk(backgroundRequest, 1'b0);
    acc(1'b1, 16'hFF01, 8'hC0);
    pulseEnter();
    n = 16'h0000;
    while (serialEnable !== 1'b1 && n < 16'h001E) begin
      @(negedge mclk);
      n++;
    end
    chk(serialEnable, 1'b1);
  endtask
  task testIdle;
    host.sendCmd(8'h90, 450);
    chk(backgroundRequest, 1'b1);
    repeat (100) @(negedge mclk);
    chk(backgroundRequest, 1'b0);
  endtask
  task testLockout;
    doReset(2'h0, 8'h7F); // only the lockout bit programmed low
    chk({lockoutActive, debugActive}, 2'b10);
    chk(resetVectorBlock, 1'b1);
    rdChk(16'hFF01, 8'h00);
    pulseEnter();
    chk(debugActive, 1'b0);
    doReset(2'h2, 8'h7F);
    chk(resetVectorBlock, 1'b0);
    doReset(2'h1, 8'hFF);
    chk({lockoutActive, debugActive}, 2'b01);
  endtask
  task end_of_test;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // every input settled at time zero, then the scenarios in turn
  initial begin
    mismatches = 0;
    tests_run = 0;
    {nrst, eClkSlow, shiftDone, addrLoad, enterDebug, busSel, busWr} = 7'h00;
    debugClkTick = 1'b1;
    modeSel = 2'h0;
    shadowByte = 8'hFF;
    {userCcr, busWdata, shiftIn, addrIn, busAddr} = 64'h0;
    @(negedge mclk);
    testResetRegs();
    testStatusWrite();
    testHwCmd();
    testFwDecode();
    testIdle();
    testLockout();
    end_of_test();
  end
endmodule
`default_nettype wire
